// >>> hw/idle_standby_timer.sv
// idle command handling and automatic standby timer behind the task file
// assumes host strobes are synchronous to core_clk, one cycle each
//
// Functional notes
// - opcodes E3h and 97h both mean idle
// - accept: enter idle, load and start timer
// - spin up on entry unless already spinning
// - idle keeps spindle up, ready at once
// - timeout code zero disables auto standby
// - codes 1-240 x5 seconds, 241-251 x30 minutes
// - codes 252-255 map to fixed intervals
// - expiry in idle without host access enters standby; an expiry during spin-up is dropped
// - host access reloads full timer interval
`default_nettype none

module idle_standby_timer #(
  parameter int TICK_CYCLES = idle_standby_pkg::TICK_CYCLES_DEF,
  parameter logic DEV_SEL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // task-file host port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // spindle
  input wire logic spindleReady,
  output logic spindleOn,
  // power state
  output logic inStandby
);

  // ****************************************
  // host port decode
  // ****************************************
  logic hostAccess, cmdAccept, idleAccept, badAccept;
  logic timerLoad, timerArmed, timerExpired;
  logic [idle_standby_pkg::SEC_W-1:0] timerSeconds, timerRemain;
  logic [7:0] statusVal;

  idle_standby_pkg::pwr_state_t state_reg, state_next;
  logic busy_reg, busy_next;
  logic [7:0] err_reg, err_next;
  logic [7:0] code_reg, code_next;
  logic [7:0] drive_reg, drive_next;
  logic [7:0] rd_reg, rd_next;
  logic [idle_standby_pkg::SEC_W-1:0] intv_reg, intv_next;

  // commands while busy or for the other drive are ignored
  assign hostAccess = regWrite || regRead;
  assign cmdAccept = regWrite && (regAddr == idle_standby_pkg::ADDR_CMD) && !busy_reg &&
                     (drive_reg[idle_standby_pkg::SEL_DEV] == DEV_SEL);
  assign idleAccept = cmdAccept && idle_standby_pkg::is_idle_op(regWrData);
  assign badAccept = cmdAccept && !idle_standby_pkg::is_idle_op(regWrData);

  // ****************************************
  // standby timer
  // ****************************************
  // load on accept
  // reload on host access
  // a fresh command wins over a plain reload in the same cycle
  assign timerLoad = idleAccept || (hostAccess && timerArmed);
  assign timerSeconds = idleAccept ? idle_standby_pkg::interval_seconds(code_reg) : intv_reg;

  standby_countdown #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_countdown (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(timerLoad),
    .loadSeconds(timerSeconds),
    .armed(timerArmed),
    .expired(timerExpired),
    .remaining(timerRemain)
  );

  // ****************************************
  // status and command state
  // ****************************************
  // busy, ready when not busy, seek complete only in idle
  always_comb
  begin
    statusVal = idle_standby_pkg::BYTE_RESET;
    statusVal[idle_standby_pkg::ST_BSY] = busy_reg;
    statusVal[idle_standby_pkg::ST_RDY] = !busy_reg;
    statusVal[idle_standby_pkg::ST_DSC] = (state_reg == idle_standby_pkg::PWR_IDLE);
    statusVal[idle_standby_pkg::ST_ERR] = (err_reg != idle_standby_pkg::BYTE_RESET);
  end

  // next values of the command, power and register state
  always_comb
  begin
    state_next = state_reg;
    busy_next = busy_reg;
    err_next = err_reg;
    code_next = code_reg;
    drive_next = drive_reg;
    intv_next = intv_reg;
    rd_next = rd_reg;
    if (regWrite && (regAddr == idle_standby_pkg::ADDR_COUNT))
      code_next = regWrData;
    if (regWrite && (regAddr == idle_standby_pkg::ADDR_SELECT))
      drive_next = regWrData;
    case (state_reg)
      idle_standby_pkg::PWR_SPINUP:
      begin
        // idle only once spindle at speed
        if (spindleReady)
        begin
          state_next = idle_standby_pkg::PWR_IDLE;
          busy_next = 1'b0;
        end
      end
      idle_standby_pkg::PWR_IDLE:
      begin
        if (timerExpired)
          state_next = idle_standby_pkg::PWR_STANDBY;
      end
      default:
        state_next = state_reg;
    endcase
    if (idleAccept)
    begin
      err_next = idle_standby_pkg::BYTE_RESET;
      intv_next = idle_standby_pkg::interval_seconds(code_reg);
      if (spindleReady)
      begin
        state_next = idle_standby_pkg::PWR_IDLE;
        busy_next = 1'b0;
      end
      else
      begin
        state_next = idle_standby_pkg::PWR_SPINUP;
        busy_next = 1'b1;
      end
    end
    if (badAccept)
      err_next = idle_standby_pkg::ERR_ABORT;
    // read data registered; unmapped addresses read zero
    if (regRead)
    begin
      case (regAddr)
        idle_standby_pkg::ADDR_ERROR: rd_next = err_reg;
        idle_standby_pkg::ADDR_COUNT: rd_next = code_reg;
        idle_standby_pkg::ADDR_SELECT: rd_next = drive_reg;
        idle_standby_pkg::ADDR_CMD: rd_next = statusVal;
        default: rd_next = idle_standby_pkg::BYTE_RESET;
      endcase
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= idle_standby_pkg::PWR_STANDBY;
      busy_reg <= 1'b0;
      err_reg <= idle_standby_pkg::BYTE_RESET;
      code_reg <= idle_standby_pkg::BYTE_RESET;
      drive_reg <= idle_standby_pkg::BYTE_RESET;
      intv_reg <= '0;
      rd_reg <= idle_standby_pkg::BYTE_RESET;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
      code_reg <= code_next;
      drive_reg <= drive_next;
      intv_reg <= intv_next;
      rd_reg <= rd_next;
    end
  end

  // spindle runs in spin-up and idle, stops in standby
  assign spindleOn = (state_reg != idle_standby_pkg::PWR_STANDBY);
  assign inStandby = (state_reg == idle_standby_pkg::PWR_STANDBY);
  assign regRdData = rd_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  opcode_decode_a: assert property (
    idleAccept |=> spindleOn && (err_reg == idle_standby_pkg::BYTE_RESET))
    else $error("idle opcode not handled as idle");
  idle_entry_a: assert property (
    idleAccept && spindleReady |=> (state_reg == idle_standby_pkg::PWR_IDLE) && !busy_reg)
    else $error("idle not entered at once");
  spinup_path_a: assert property (
    idleAccept && !spindleReady |=> (state_reg == idle_standby_pkg::PWR_SPINUP) ##0 busy_reg
    ##0 spindleOn)
    else $error("spin-up not started");
  idle_ready_a: assert property (
    state_reg == idle_standby_pkg::PWR_IDLE |-> !busy_reg && statusVal[idle_standby_pkg::ST_RDY]
    && statusVal[idle_standby_pkg::ST_DSC])
    else $error("idle state not ready");
  zero_code_a: assert property (
    idleAccept && (code_reg == idle_standby_pkg::CODE_OFF) |=> !timerArmed [*3])
    else $error("zero code left timer armed");
  interval_map_a: assert property (
    idleAccept |=> timerRemain == idle_standby_pkg::interval_seconds($past(code_reg)))
    else $error("timer loaded with wrong interval");
  fixed_code_a: assert property (
    idleAccept && (code_reg == idle_standby_pkg::CODE_8H) |=>
    timerRemain == idle_standby_pkg::T_8H_S)
    else $error("eight hour code mis-decoded");
  short_step_a: assert property (
    idleAccept && (code_reg == 8'h01) |=> timerRemain == idle_standby_pkg::T_SHORT_S)
    else $error("short step is not five seconds");
  standby_entry_a: assert property (
    timerExpired && (state_reg == idle_standby_pkg::PWR_IDLE) && !idleAccept |=>
    inStandby && !spindleOn)
    else $error("expiry did not enter standby");
  reload_full_a: assert property (
    hostAccess && timerArmed && !idleAccept |=> timerArmed && (timerRemain == $past(intv_reg)))
    else $error("host access did not reload timer");
  reject_flags_a: assert property (
    badAccept |=> (err_reg == idle_standby_pkg::ERR_ABORT) && statusVal[idle_standby_pkg::ST_ERR]
    && !busy_reg)
    else $error("rejected command flags wrong");

  spinup_seen_c: cover property (idleAccept && !spindleReady ##[1:20] !busy_reg);
  standby_seen_c: cover property (timerExpired ##1 inStandby);
  reject_seen_c: cover property (badAccept);
  reload_seen_c: cover property (hostAccess && timerArmed && !idleAccept);

endmodule : idle_standby_timer

`default_nettype wire

// >>> hw/idle_standby_pkg.sv
// constants, state type and timeout decoding for the idle/standby timer
// assumes a 100 MHz core clock and a task-file style host port
`default_nettype none

package idle_standby_pkg;

  // ****************************************
  // task-file register addresses
  // ****************************************
  localparam logic [2:0] ADDR_ERROR = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_SELECT = 3'h6;
  localparam logic [2:0] ADDR_CMD = 3'h7;

  // ****************************************
  // opcodes, bit positions, reset values
  // ****************************************
  localparam logic [7:0] OP_IDLE = 8'he3;
  localparam logic [7:0] OP_IDLE_ALT = 8'h97;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_ERR = 0;
  localparam int ERR_ABT = 2;
  localparam int SEL_DEV = 4;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  // ****************************************
  // timing
  // ****************************************
  localparam int SECOND_NS = 1_000_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
  localparam int SEC_W = 15;
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [7:0] CODE_SHORT_MAX = 8'hf0;
  localparam logic [7:0] CODE_LONG_MAX = 8'hfb;
  localparam logic [7:0] CODE_21M = 8'hfc;
  localparam logic [7:0] CODE_8H = 8'hfd;
  localparam logic [7:0] CODE_21M10 = 8'hfe;
  localparam int STEP_SHORT_S = 5;
  localparam int STEP_LONG_MIN = 30;
  localparam logic [SEC_W-1:0] T_SHORT_S = SEC_W'(STEP_SHORT_S);
  localparam logic [SEC_W-1:0] T_LONG_S = SEC_W'(STEP_LONG_MIN * 60);
  localparam logic [SEC_W-1:0] T_21M_S = SEC_W'(21 * 60);
  localparam logic [SEC_W-1:0] T_8H_S = SEC_W'(8 * 3600);
  localparam logic [SEC_W-1:0] T_21M10_S = SEC_W'(21 * 60 + 10);
  localparam logic [SEC_W-1:0] T_21M15_S = SEC_W'(21 * 60 + 15);
  localparam logic [SEC_W-1:0] CODE_BASE = SEC_W'(240);

  typedef enum logic [1:0] {PWR_STANDBY, PWR_SPINUP, PWR_IDLE} pwr_state_t;

  // either opcode selects the same idle operation
  function automatic logic is_idle_op(input logic [7:0] op);
    is_idle_op = (op == OP_IDLE) || (op == OP_IDLE_ALT);
  endfunction : is_idle_op

  // timeout code to seconds; zero means disabled
  function automatic logic [SEC_W-1:0] interval_seconds(input logic [7:0] code);
    logic [SEC_W-1:0] c;
    c = {7'h00, code};
    if (code == CODE_OFF)
      interval_seconds = '0;
    else if (code <= CODE_SHORT_MAX)
      interval_seconds = SEC_W'(c * T_SHORT_S);
    else if (code <= CODE_LONG_MAX)
      interval_seconds = SEC_W'((c - CODE_BASE) * T_LONG_S);
    else if (code == CODE_21M)
      interval_seconds = T_21M_S;
    else if (code == CODE_8H)
      interval_seconds = T_8H_S;
    else if (code == CODE_21M10)
      interval_seconds = T_21M10_S;
    else
      interval_seconds = T_21M15_S;
  endfunction : interval_seconds

endpackage : idle_standby_pkg

`default_nettype wire

// >>> hw/standby_countdown.sv
// seconds countdown with a one-second prescaler for the standby timer
// assumes load is a one-cycle strobe from the command logic
`default_nettype none

module standby_countdown #(
  parameter int TICK_CYCLES = idle_standby_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [idle_standby_pkg::SEC_W-1:0] loadSeconds,
  // status
  output logic armed,
  output logic expired,
  output logic [idle_standby_pkg::SEC_W-1:0] remaining
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam logic [idle_standby_pkg::SEC_W-1:0] ONE_S = 15'h0001;

  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [idle_standby_pkg::SEC_W-1:0] rem_reg, rem_next;
  logic arm_reg, arm_next, exp_reg, exp_next;

  // a load restarts the prescaler too, so a reload is a full interval
  always_comb
  begin
    pre_next = pre_reg;
    rem_next = rem_reg;
    arm_next = arm_reg;
    exp_next = 1'b0;
    if (load)
    begin
      pre_next = '0;
      rem_next = loadSeconds;
      arm_next = (loadSeconds != '0);
    end
    else if (arm_reg)
    begin
      if (pre_reg == TICK_LAST)
      begin
        pre_next = '0;
        rem_next = rem_reg - ONE_S;
        if (rem_reg == ONE_S)
        begin
          arm_next = 1'b0;
          exp_next = 1'b1;
        end
      end
      else
        pre_next = pre_reg + PRE_W'(1);
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= '0;
      rem_reg <= '0;
      arm_reg <= 1'b0;
      exp_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      rem_reg <= rem_next;
      arm_reg <= arm_next;
      exp_reg <= exp_next;
    end
  end

  assign armed = arm_reg;
  assign expired = exp_reg;
  assign remaining = rem_reg;

  expire_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    expired |-> !armed ##1 !expired)
    else $error("expiry pulse not single or timer still armed");

endmodule : standby_countdown

`default_nettype wire

// >>> test/host_model.sv
// host-side model that drives the task-file register port
// assumes one strobe per access, synchronous to core_clk
`default_nettype none

module host_model (
  // clock
  input wire logic core_clk,
  // task-file port
  output logic regWrite,
  output logic regRead,
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet bus at time zero
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    // scramble idle data so a stale byte is never taken
    regWrData <= ~d;
  endtask : wr

  // read waits a spare edge so the answer has landed
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    d = regRdData;
  endtask : rd
endmodule : host_model

`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the idle/standby timer
// assumes one clock; prescaler shortened to two cycles per second
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 2; // two, so the prescaler really counts and restarts
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spindleReady = 1'b1;
  logic regWrite, regRead, spindleOn, inStandby;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, rv, op;
  int n_errors = 0;
  int tests_run = 0;
  int codes[8] = '{0, 1, 240, 241, 252, 254, 255, 253};

  // ************************************
  // clock, dut, host
  // ************************************
  always #5 core_clk = ~core_clk;

  idle_standby_timer #(.TICK_CYCLES(TICK), .DEV_SEL(1'b0)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .spindleReady(spindleReady), .spindleOn(spindleOn), .inStandby(inStandby));

  host_model i_host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  // ************************************
  // helpers
  // ************************************
  function automatic int exp_secs(input int c);
    exp_secs = c <= 240 ? c * 5 : c <= 251 ? (c - 240) * 1800 :
      c == 252 ? 1260 : c == 253 ? 28800 : c == 254 ? 1270 : 1275;
  endfunction : exp_secs

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    i_host.rd(a, rv);
    chk8(rv, e);
  endtask : rdc

  task automatic cmd(input logic [7:0] c, input logic [7:0] o);
    i_host.wr(idle_standby_pkg::ADDR_COUNT, c);
    i_host.wr(idle_standby_pkg::ADDR_SELECT, 8'h00);
    i_host.wr(idle_standby_pkg::ADDR_CMD, o);
  endtask : cmd

  // still idle just before n cycles, standby a few cycles after
  task automatic expiry(input int n);
    repeat (n - 1) @(posedge core_clk);
    @(negedge core_clk);
    chk1(inStandby, 1'b0);
    chk1(spindleOn, 1'b1);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk1(inStandby, 1'b1);
    chk1(spindleOn, 1'b0);
  endtask : expiry

  task automatic end_sim;
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // watchdog well beyond the longest interval plus overhead
  initial
  begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    void'($urandom(35509));
    codes[0] = $urandom_range(239, 2);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk1(inStandby, 1'b1);
    rdc(idle_standby_pkg::ADDR_CMD, 8'h40);
    rdc(idle_standby_pkg::ADDR_ERROR, 8'h00);
    // read-back and an unmapped address
    op = 8'($urandom);
    i_host.wr(idle_standby_pkg::ADDR_COUNT, op);
    rdc(idle_standby_pkg::ADDR_COUNT, op);
    rdc(3'h3, 8'h00);
    // other drive selected: command must be ignored
    i_host.wr(idle_standby_pkg::ADDR_SELECT, 8'h10);
    rdc(idle_standby_pkg::ADDR_SELECT, 8'h10);
    i_host.wr(idle_standby_pkg::ADDR_CMD, idle_standby_pkg::OP_IDLE);
    @(negedge core_clk);
    chk1(inStandby, 1'b1);
    // unknown opcode is rejected with abort
    i_host.wr(idle_standby_pkg::ADDR_SELECT, 8'h00);
    do
      op = 8'($urandom);
    while (op == idle_standby_pkg::OP_IDLE || op == idle_standby_pkg::OP_IDLE_ALT);
    i_host.wr(idle_standby_pkg::ADDR_CMD, op);
    rdc(idle_standby_pkg::ADDR_ERROR, 8'h04);
    rdc(idle_standby_pkg::ADDR_CMD, 8'h41);
    // stopped spindle: busy until at speed
    @(posedge core_clk);
    spindleReady <= 1'b0;
    cmd(8'h00, idle_standby_pkg::OP_IDLE_ALT);
    @(negedge core_clk);
    chk1(spindleOn, 1'b1);
    rdc(idle_standby_pkg::ADDR_CMD, 8'h80);
    // a command while busy is ignored, so no abort may follow
    i_host.wr(idle_standby_pkg::ADDR_CMD, 8'h00);
    @(posedge core_clk);
    spindleReady <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdc(idle_standby_pkg::ADDR_CMD, 8'h50);
    rdc(idle_standby_pkg::ADDR_ERROR, 8'h00);
    // code zero: never powers down
    repeat (3000) @(posedge core_clk);
    @(negedge core_clk);
    chk1(inStandby, 1'b0);
    rdc(idle_standby_pkg::ADDR_CMD, 8'h50);
    // every nonzero code class, opcodes alternating
    foreach (codes[i])
    begin
      cmd(8'(codes[i]), i % 2 ? idle_standby_pkg::OP_IDLE_ALT : idle_standby_pkg::OP_IDLE);
      expiry(exp_secs(codes[i]) * TICK);
      rdc(idle_standby_pkg::ADDR_CMD, 8'h40);
    end
    // access late in the interval restarts the full count
    cmd(8'h04, idle_standby_pkg::OP_IDLE);
    repeat (30) @(posedge core_clk);
    rdc(idle_standby_pkg::ADDR_COUNT, 8'h04);
    expiry(20 * TICK);
    end_sim();
  end
endmodule : tb

`default_nettype wire
